/* src/sweep_pkg.sv */
// Constants shared by the linear frequency sweeper, its checker and its bench.
// Assumes a single reference clock domain and a register port that is fed
// by the serial-port logic elsewhere in the synthesizer.
package sweep_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam logic [5:0] ADDR_CONTROL = 6'h14;
   localparam logic [5:0] ADDR_INCREMENT = 6'h15;
   localparam logic [5:0] ADDR_COUNT = 6'h16;
   localparam logic [5:0] ADDR_HOLD = 6'h17;
   localparam logic [5:0] ADDR_STATUS = 6'h1f;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_CLEAR_FLAGS = 0;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_TRIGGER = 2;
   localparam int BIT_REPEAT = 3;
   localparam int BIT_BEGIN_DOWNWARD = 4;
   localparam int BIT_EXT_TRIGGER = 5;
   localparam int BIT_SINGLE_STEP = 6;
   localparam int BIT_ONE_WAY = 7;
   localparam int BIT_STATUS_ACTIVE = 5;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [23:0] INCREMENT_RESET = 24'h000800;
   localparam logic [23:0] COUNT_RESET = 24'h000800;
   localparam logic [23:0] HOLD_RESET = 24'h000800;

   // ------------------------------------------------------------
   // Frequency word and sweeper states
   // ------------------------------------------------------------
   localparam int FREQ_W = 40;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RAMP,
      ST_PAUSE,
      ST_DWELL
   } sweep_state_t;

endpackage

/* src/trigger_edge.sv */
// Pin synchroniser with rising-edge detector for the external sweep start.
// Assumes the pin is asynchronous to the clock and may toggle at any time.
module trigger_edge (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Raw pin and detected edge
   input wire logic pin_in,
   output logic rise_pulse
);

   // ------------------------------------------------------------
   // Two-stage synchroniser followed by an edge register
   // ------------------------------------------------------------
   logic meta_r;  // First stage; only the second stage reads it.
   logic sync_r;  // Second stage, safe to use in logic.
   logic last_r;  // Previous synchronised level for edge detection.

   // The first stage is kept private so metastability cannot fan out.
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
         rise_pulse <= 1'b0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         last_r <= sync_r;
         rise_pulse <= sync_r & ~last_r;
      end
   end

endmodule

/* src/freq_sweeper.sv */
// Continuous-wave linear frequency sweeper control.
// Assumes the serial-port logic presents decoded register writes and reads
// on the reference clock, and that the sweep output word feeds the divider.
module freq_sweeper
   import sweep_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // Register port from the serial interface
   input wire logic REG_WR_EN,
   input wire logic [sweep_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [sweep_pkg::DATA_W-1:0] REG_WR_DATA,
   output logic [sweep_pkg::DATA_W-1:0] REG_RD_DATA,
   // Frequency word interface to the divider
   input wire logic [sweep_pkg::FREQ_W-1:0] BASE_FREQ_WORD,
   output logic [sweep_pkg::FREQ_W-1:0] FREQ_WORD,
   // Range flags and sweep status
   output logic OVERFLOW_FLAG,
   output logic UNDERFLOW_FLAG,
   output logic SWEEP_ACTIVE_FLAG,
   // External trigger pin
   input wire logic GENERAL_OUTPUT_PIN_THREE
);
   import sweep_pkg::*;

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [7:0] control_r;  // Sweep control bits.
   logic [DATA_W-1:0] increment_r;  // Frequency change per step.
   logic [DATA_W-1:0] count_r;  // Steps per sweep.
   logic [DATA_W-1:0] hold_r;  // Dwell cycles at an extreme.

   // ------------------------------------------------------------
   // Sweep state
   // ------------------------------------------------------------
   sweep_state_t state_r, state_nxt;  // Sequencer state.
   logic [FREQ_W-1:0] pos_r, pos_nxt;  // Present frequency word.
   logic [FREQ_W-1:0] start_r, start_nxt;  // Word that a sweep began at.
   logic dir_down_r, dir_down_nxt;  // Present direction, 1 is downward.
   logic [DATA_W-1:0] step_cnt_r, step_cnt_nxt;  // Steps done.
   logic [DATA_W-1:0] dwell_cnt_r, dwell_cnt_nxt;  // Dwell cycles done.
   logic armed_r, armed_nxt;  // Start word captured since enable.

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   wire wr_control = REG_WR_EN && (REG_ADDR == ADDR_CONTROL);
   wire wr_increment = REG_WR_EN && (REG_ADDR == ADDR_INCREMENT);
   wire wr_count = REG_WR_EN && (REG_ADDR == ADDR_COUNT);
   wire wr_hold = REG_WR_EN && (REG_ADDR == ADDR_HOLD);
   wire enabled = control_r[BIT_ENABLE];
   wire repeat_on = control_r[BIT_REPEAT];
   wire one_way = control_r[BIT_ONE_WAY];
   wire single_step = control_r[BIT_SINGLE_STEP];
   wire clear_flags = control_r[BIT_CLEAR_FLAGS];

   // A trigger only counts when the bit goes from zero to one.
   wire sw_trigger = wr_control && REG_WR_DATA[BIT_TRIGGER] &&
                     !control_r[BIT_TRIGGER];

   // External edge, honoured only when the pin trigger is allowed.
   logic ext_rise;  // Synchronised rising edge of the trigger pin.
   wire ext_trigger = ext_rise && control_r[BIT_EXT_TRIGGER];
   wire trigger = enabled && (sw_trigger || ext_trigger);

   // Unsigned step with carry: the extra bit exposes wrap of the word.
   wire [FREQ_W:0] step_ext = {{(FREQ_W + 1 - DATA_W){1'b0}}, increment_r};
   wire [FREQ_W:0] sum_up = {1'b0, pos_r} + step_ext;
   wire [FREQ_W:0] sum_dn = {1'b0, pos_r} - step_ext;
   wire [FREQ_W:0] stepped = dir_down_r ? sum_dn : sum_up;
   wire last_step = (step_cnt_r + 24'h000001) >= count_r;
   wire dwell_done = (dwell_cnt_r + 24'h000001) >= hold_r;
   wire stepping = (state_r == ST_RAMP);
   wire step_ovf = stepping && !dir_down_r && sum_up[FREQ_W];
   wire step_udf = stepping && dir_down_r && sum_dn[FREQ_W];

   // ------------------------------------------------------------
   // External trigger synchroniser
   // ------------------------------------------------------------
   trigger_edge u_trigger_edge (
      .clk(CORE_CLK),
      .rst(RESET),
      .pin_in(GENERAL_OUTPUT_PIN_THREE),
      .rise_pulse(ext_rise)
   );

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Plain stores; the trigger bit keeps whatever software wrote so that
   // a second start needs an explicit write of zero first.
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         control_r <= CONTROL_RESET;
         increment_r <= INCREMENT_RESET;
         count_r <= COUNT_RESET;
         hold_r <= HOLD_RESET;
      end else begin
         if (wr_control) begin
            control_r <= REG_WR_DATA[7:0];
         end
         if (wr_increment) begin
            increment_r <= REG_WR_DATA;
         end
         if (wr_count) begin
            count_r <= REG_WR_DATA;
         end
         if (wr_hold) begin
            hold_r <= REG_WR_DATA;
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   // End of a sweep: one-way hops back, otherwise the direction reverses.
   always_comb begin
      state_nxt = state_r;
      pos_nxt = pos_r;
      start_nxt = start_r;
      dir_down_nxt = dir_down_r;
      step_cnt_nxt = step_cnt_r;
      dwell_cnt_nxt = dwell_cnt_r;
      armed_nxt = armed_r;
      if (!enabled) begin
         // Disabled: sweeper held in reset, tracking the base word.
         state_nxt = ST_IDLE;
         pos_nxt = BASE_FREQ_WORD;
         start_nxt = BASE_FREQ_WORD;
         dir_down_nxt = control_r[BIT_BEGIN_DOWNWARD];
         step_cnt_nxt = '0;
         dwell_cnt_nxt = '0;
         armed_nxt = 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (!armed_r) begin
                  // Until the first sweep the word follows the base.
                  pos_nxt = BASE_FREQ_WORD;
                  start_nxt = BASE_FREQ_WORD;
                  dir_down_nxt = control_r[BIT_BEGIN_DOWNWARD];
               end
               if (trigger) begin
                  state_nxt = ST_RAMP;
                  step_cnt_nxt = '0;
                  armed_nxt = 1'b1;
                  if (!armed_r) begin
                     start_nxt = BASE_FREQ_WORD;
                  end
               end
            end
            ST_RAMP: begin
               pos_nxt = stepped[FREQ_W-1:0];
               step_cnt_nxt = step_cnt_r + 24'h000001;
               if (last_step) begin
                  step_cnt_nxt = '0;
                  dwell_cnt_nxt = '0;
                  if (repeat_on) begin
                     state_nxt = ST_DWELL;
                  end else begin
                     state_nxt = ST_IDLE;
                     if (one_way) begin
                        pos_nxt = start_r;
                     end else begin
                        dir_down_nxt = !dir_down_r;
                     end
                  end
               end else if (single_step) begin
                  state_nxt = ST_PAUSE;
               end
            end
            ST_PAUSE: begin
               // Frequency held; each further trigger gives one step.
               if (trigger || !single_step) begin
                  state_nxt = ST_RAMP;
               end
            end
            ST_DWELL: begin
               dwell_cnt_nxt = dwell_cnt_r + 24'h000001;
               if (dwell_done) begin
                  if (!repeat_on) begin
                     // Repeat dropped during dwell: finish here.
                     state_nxt = ST_IDLE;
                  end else begin
                     state_nxt = ST_RAMP;
                  end
                  if (one_way) begin
                     pos_nxt = start_r;
                  end else begin
                     dir_down_nxt = !dir_down_r;
                  end
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         state_r <= ST_IDLE;
         pos_r <= '0;
         start_r <= '0;
         dir_down_r <= 1'b0;
         step_cnt_r <= '0;
         dwell_cnt_r <= '0;
         armed_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pos_r <= pos_nxt;
         start_r <= start_nxt;
         dir_down_r <= dir_down_nxt;
         step_cnt_r <= step_cnt_nxt;
         dwell_cnt_r <= dwell_cnt_nxt;
         armed_r <= armed_nxt;
      end
   end

   // ------------------------------------------------------------
   // Range flags
   // ------------------------------------------------------------
   // The clear acts as a level without waiting for an edge, so a wrap that
   // lands while it is held is lost; software must release it first.
   always_ff @(posedge CORE_CLK or posedge clear_flags) begin
      if (clear_flags) begin
         OVERFLOW_FLAG <= 1'b0;
         UNDERFLOW_FLAG <= 1'b0;
      end else if (RESET) begin
         OVERFLOW_FLAG <= 1'b0;
         UNDERFLOW_FLAG <= 1'b0;
      end else begin
         OVERFLOW_FLAG <= OVERFLOW_FLAG | step_ovf;
         UNDERFLOW_FLAG <= UNDERFLOW_FLAG | step_udf;
      end
   end

   // ------------------------------------------------------------
   // Outputs and read-back
   // ------------------------------------------------------------
   // Active through ramp, pause and dwell; low once the sweep has ended.
   wire active = enabled && (state_r != ST_IDLE);
   wire [DATA_W-1:0] status_word = {{(DATA_W - 1 - BIT_STATUS_ACTIVE){1'b0}},
                                    SWEEP_ACTIVE_FLAG,
                                    {BIT_STATUS_ACTIVE{1'b0}}};
   wire [DATA_W-1:0] rd_mux =
      (REG_ADDR == ADDR_CONTROL) ? {16'h0000, control_r} :
      (REG_ADDR == ADDR_INCREMENT) ? increment_r :
      (REG_ADDR == ADDR_COUNT) ? count_r :
      (REG_ADDR == ADDR_HOLD) ? hold_r :
      (REG_ADDR == ADDR_STATUS) ? status_word : 24'h000000;

   // Read data and status leave through flip-flops.
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         REG_RD_DATA <= '0;
         FREQ_WORD <= '0;
         SWEEP_ACTIVE_FLAG <= 1'b0;
      end else begin
         REG_RD_DATA <= rd_mux;
         FREQ_WORD <= pos_nxt;
         SWEEP_ACTIVE_FLAG <= active;
      end
   end

endmodule

/* bench/trig_source.sv */
// Stand-in for the external sweep-start source on pin three.
// Assumes the bench calls pulse from its main sequence.
module trig_source (
   // Reference clock and pin
   input wire logic clk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // The pin idles low until a start is wanted.
   initial pin = 1'b0;

   // Edges land mid-cycle, as a truly asynchronous source would.
   task automatic pulse(input int cycles);
      @(posedge clk);
      #3 pin = 1'b1;
      repeat (cycles) @(posedge clk);
      #3 pin = 1'b0;
   endtask
endmodule

/* bench/freq_sweeper_assertions.sv */
// Port checks for the sweeper, bound to freq_sweeper.
// Assumes sweeps are not re-armed or retuned by software mid-flight.
module sweep_checker
   import sweep_pkg::*;
(
   // Clock, reset and register port
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic REG_WR_EN,
   input wire logic [sweep_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [sweep_pkg::DATA_W-1:0] REG_WR_DATA,
   input wire logic [sweep_pkg::DATA_W-1:0] REG_RD_DATA,
   // Words, flags and pin
   input wire logic [sweep_pkg::FREQ_W-1:0] BASE_FREQ_WORD,
   input wire logic [sweep_pkg::FREQ_W-1:0] FREQ_WORD,
   input wire logic OVERFLOW_FLAG,
   input wire logic UNDERFLOW_FLAG,
   input wire logic SWEEP_ACTIVE_FLAG,
   input wire logic GENERAL_OUTPUT_PIN_THREE
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Shadow registers
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   logic [7:0] ctl_r; // Control as last written.
   logic [23:0] inc_r; // Increment as last written.
   wire ctl_wr = REG_WR_EN && REG_ADDR == ADDR_CONTROL;
   wire [39:0] inc_w = {16'h0000, inc_r};

   // Rebuilt from writes so checks need no view inside.
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         ctl_r <= CONTROL_RESET;
         inc_r <= INCREMENT_RESET;
      end else begin
         if (ctl_wr) ctl_r <= REG_WR_DATA[7:0];
         if (REG_WR_EN && REG_ADDR == ADDR_INCREMENT) inc_r <= REG_WR_DATA;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_clear_flags: assert property (ctl_wr && REG_WR_DATA[0]
      |-> ##2 !OVERFLOW_FLAG && !UNDERFLOW_FLAG)
      else $error("range flag survived a clear");
   a_disable_idles: assert property (ctl_wr && !REG_WR_DATA[1]
      |-> ##[2:3] !SWEEP_ACTIVE_FLAG) else $error("sweep kept running");
   a_soft_start: assert property (ctl_wr && REG_WR_DATA[2:1] == 2'b11
      && ctl_r[2:1] == 2'b01 && !SWEEP_ACTIVE_FLAG |-> ##2 SWEEP_ACTIVE_FLAG)
      else $error("trigger write started nothing");
   a_no_retrigger: assert property (ctl_wr && REG_WR_DATA[2]
      && ctl_r[2] && !ctl_r[3] && !SWEEP_ACTIVE_FLAG
      |-> ##2 !SWEEP_ACTIVE_FLAG) else $error("held trigger restarted");
   a_step_size: assert property (SWEEP_ACTIVE_FLAG
      && $past(SWEEP_ACTIVE_FLAG) && ctl_r[1] && $past(ctl_r[1])
      && !ctl_r[7] && FREQ_WORD != $past(FREQ_WORD)
      |-> FREQ_WORD - $past(FREQ_WORD) == inc_w
      || $past(FREQ_WORD) - FREQ_WORD == inc_w) else $error("bad step");
   a_pin_start: assert property ($rose(GENERAL_OUTPUT_PIN_THREE)
      && ctl_r[5] && ctl_r[1] && !SWEEP_ACTIVE_FLAG
      |-> ##[3:6] SWEEP_ACTIVE_FLAG) else $error("pin edge was lost");
   a_pin_ignored: assert property ($rose(GENERAL_OUTPUT_PIN_THREE)
      && !ctl_r[5] && !SWEEP_ACTIVE_FLAG ##1 (!REG_WR_EN)[*6]
      |-> !SWEEP_ACTIVE_FLAG) else $error("disabled pin started a sweep");
   a_inc_readback: assert property (!REG_WR_EN
      && REG_ADDR == ADDR_INCREMENT |=> REG_RD_DATA == $past(inc_r))
      else $error("increment read back wrong");
endmodule

bind freq_sweeper sweep_checker chk_u (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .REG_WR_EN(REG_WR_EN),
   .REG_ADDR(REG_ADDR), .REG_WR_DATA(REG_WR_DATA),
   .REG_RD_DATA(REG_RD_DATA), .BASE_FREQ_WORD(BASE_FREQ_WORD),
   .FREQ_WORD(FREQ_WORD), .OVERFLOW_FLAG(OVERFLOW_FLAG),
   .UNDERFLOW_FLAG(UNDERFLOW_FLAG), .SWEEP_ACTIVE_FLAG(SWEEP_ACTIVE_FLAG),
   .GENERAL_OUTPUT_PIN_THREE(GENERAL_OUTPUT_PIN_THREE)
);

/* bench/linear_frequency_sweeper_tb_top.sv */
// Self-checking bench for the sweeper with random steps and counts.
// Assumes the checker binds itself and trig_source drives pin three.
module linear_frequency_sweeper_tb_top import sweep_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr_en = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [23:0] wdata = 24'h000000;
   logic [39:0] base = 40'h0000000000;
   logic [23:0] rdata, inc, steps;
   logic [39:0] freq;
   logic ovf, udf, act, pin;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   int hold_seen; // Cycles the word sat at the top of a repeat sweep.
   logic [39:0] top_w; // Expected top word of the repeat sweep.
   logic [31:0] seed = 32'h0e999c66; // Fixed so runs repeat.
   freq_sweeper dut_u (.CORE_CLK(clk), .RESET(rst), .REG_WR_EN(wr_en),
      .REG_ADDR(addr), .REG_WR_DATA(wdata), .REG_RD_DATA(rdata),
      .BASE_FREQ_WORD(base), .FREQ_WORD(freq), .OVERFLOW_FLAG(ovf),
      .UNDERFLOW_FLAG(udf), .SWEEP_ACTIVE_FLAG(act),
      .GENERAL_OUTPUT_PIN_THREE(pin));
   trig_source trig_u (.clk(clk), .pin(pin));
   initial forever #5 clk = ~clk;
   // A hang counts as a mismatch; the whole run needs far fewer cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         results();
      end
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Word after n steps of size s from b, downward when dn is set.
   function automatic logic [39:0] end_word(input logic [39:0] b,
      input logic [23:0] s, n, input logic dn);
      logic [39:0] span;
      span = 40'(s) * 40'(n);
      return dn ? b - span : b + span;
   endfunction
   task automatic check(input logic [39:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data shows one edge after the address is taken.
   task automatic rd(input logic [5:0] a, input logic [23:0] exp);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      #1 check(40'(rdata), 40'(exp));
   endtask
   task automatic wait_act(input logic lvl);
      for (int i = 0; i < 400 && act !== lvl; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic wait_word(input logic [39:0] w);
      for (int i = 0; i < 400 && freq !== w; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   // Idle, arm with trigger low, then trigger and, unless repeating, wait for the end.
   task automatic run(input logic [7:0] c);
      wr(ADDR_CONTROL, 24'h000000);
      wr(ADDR_CONTROL, 24'(c & 8'hfb));
      wr(ADDR_CONTROL, 24'(c));
      @(posedge clk);
      #1 check(40'(act), 40'h1);
      // Repeat mode never ends by itself, so only single sweeps are awaited.
      if (!c[BIT_REPEAT]) begin
         wait_act(1'b0);
      end
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CONTROL, 24'(CONTROL_RESET));
      rd(ADDR_INCREMENT, 24'h000800);
      rd(ADDR_COUNT, 24'h000800);
      rd(ADDR_HOLD, 24'h000800);
      rd(6'h20, 24'h000000);
      for (int k = 0; k < 4; k++) begin
         // Small steps and counts keep every span well inside the range.
         inc = 24'(rnd() & 32'hff) + 24'h000001;
         steps = 24'(rnd() & 32'h3) + 24'h000001;
         @(posedge clk);
         base <= {8'h00, rnd()};
         wr(ADDR_INCREMENT, inc);
         wr(ADDR_COUNT, steps);
         rd(ADDR_COUNT, steps);
         run(8'h06);
         check(freq, end_word(base, inc, steps, 1'b0));
         rd(ADDR_STATUS, 24'h000000);
         wr(ADDR_CONTROL, 24'h000006);
         repeat (4) @(posedge clk);
         #1 check(40'(act), 40'h0);
         run(8'h16);
         check(freq, end_word(base, inc, steps, 1'b1));
         run(8'h86);
         check(freq, base);
         wr(ADDR_CONTROL, 24'h000000);
         wr(ADDR_CONTROL, 24'h000022);
         trig_u.pulse(1);
         wait_act(1'b1);
         wait_act(1'b0);
         check(freq, end_word(base, inc, steps, 1'b0));
      end
      wr(ADDR_CONTROL, 24'h000002);
      trig_u.pulse(1);
      repeat (8) @(posedge clk);
      #1 check(40'(act), 40'h0);
      @(posedge clk);
      base <= 40'hffffffffff;
      run(8'h06);
      check(40'(ovf), 40'h1);
      @(posedge clk);
      base <= 40'h0000000000;
      run(8'h16);
      check(40'(udf), 40'h1);
      wr(ADDR_CONTROL, 24'h000001);
      repeat (2) @(posedge clk);
      #1 check(40'({ovf, udf}), 40'h0);
      @(posedge clk);
      base <= 40'h0000100000;
      wr(ADDR_COUNT, 24'h000003);
      wr(ADDR_HOLD, 24'h000004);
      run(8'h0e);
      top_w = end_word(base, inc, 24'h000003, 1'b0);
      wait_word(top_w);
      // The top shows on its landing cycle and then for the four hold cycles.
      for (hold_seen = 0; hold_seen < 20 && freq === top_w; hold_seen++) begin
         @(posedge clk);
         #1;
      end
      check(40'(hold_seen), 40'h5);
      wait_word(base);
      check(freq, base);
      wait_word(top_w);
      check(40'(act), 40'h1);
      rd(ADDR_STATUS, 24'h000001 << BIT_STATUS_ACTIVE);
      wr(ADDR_CONTROL, 24'h000000);
      wr(ADDR_CONTROL, 24'h000042);
      wr(ADDR_CONTROL, 24'h000046);
      wr(ADDR_CONTROL, 24'h000042);
      wr(ADDR_CONTROL, 24'h000046);
      repeat (6) @(posedge clk);
      #1 check(freq, end_word(base, inc, 24'h000002, 1'b0));
      wr(ADDR_CONTROL, 24'h000000);
      repeat (3) @(posedge clk);
      #1 check({act, freq[38:0]}, {1'b0, base[38:0]});
      results();
   end
endmodule
